/* src/uhs_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the USB host state block.
// Assumes: 25 MHz mclk; register indices are word indices on APB (byte address = index * 4).
// Notes:   Definitions only; included by the main module.
`ifndef UHS_CONSTS_SVH
`define UHS_CONSTS_SVH

// Clock period in nanoseconds
`define UHS_CLK_NS 40

// Register word indices
`define UHS_IDX_CONTROL 6'h01
`define UHS_IDX_CMD_STATUS 6'h02
`define UHS_IDX_INT_FLAGS 6'h03
`define UHS_IDX_INT_MASK 6'h04

// Control register field
`define UHS_FSTATE_LSB 6
`define UHS_FSTATE_MSB 7

// Command and status fields
`define UHS_SRST_BIT 0
`define UHS_OVR_CNT_LSB 16
`define UHS_OVR_CNT_MSB 17

// Interrupt flag positions, same layout in the mask register
`define UHS_INT_OVERRUN 0
`define UHS_INT_FRAME_START 2
`define UHS_INT_RESUME 3
`define UHS_INT_USED 32'h0000_000D

// Reset values
`define UHS_RESET_WORD 32'h0000_0000
`define UHS_RESET_OVR_CNT 2'h0

// Delay from entering the running state to the first frame start, and frame period
`define UHS_SOF_DELAY_MS 1
`define UHS_SOF_DELAY_CYCLES (`UHS_SOF_DELAY_MS * 1000000 / `UHS_CLK_NS)

// Longest time a software reset may take, and the cycles actually spent
`define UHS_SRST_MAX_NS 10000
`define UHS_SRST_MAX_CYCLES (`UHS_SRST_MAX_NS / `UHS_CLK_NS)
`define UHS_SRST_CYCLES 8'h20

// Cycles the root hub reset is held after hardware reset release
`define UHS_RH_RESET_CYCLES 4'h8

`endif

/* src/uhs_pkg.sv */
// Purpose: Types shared by the USB host state block.
// Assumes: Constants live in uhs_consts.svh.
// Notes:   Functional state encodings are fixed by the field.
package uhs_pkg;

	// Functional state field encodings
	typedef enum logic [1:0] {
		bus_reset_state = 2'b00,
		resuming_state = 2'b01,
		running_state = 2'b10,
		suspended_state = 2'b11
	} uhs_fstate_type;

endpackage : uhs_pkg

/* src/uhs_frame_if.sv */
// Purpose: Carrier between the state core and the frame timer.
// Assumes: Both ends on mclk.
// Notes:   run enables frame counting, sof pulses one cycle per frame start.
`timescale 1ns/10ps
interface uhs_frame_if;
	logic run;
	logic sof;

	modport core (output run, input sof);
	modport timer (input run, output sof);
endinterface : uhs_frame_if

/* src/uhs_frame_timer.sv */
// Purpose: Frame timer; first frame start one frame period after run rises, then every period.
// Assumes: run is a registered level on mclk.
// Notes:   Counter restarts whenever run falls, so each entry waits the full delay.
`timescale 1ns/10ps
module uhs_frame_timer
	import uhs_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = 25000
) (
	input wire logic mclk,
	input wire logic nrst,
	uhs_frame_if.timer frame
);

	logic [15:0] count;

	// Frame counter, cleared outside the running state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			count <= 16'h0000;
		end else if (!frame.run || count == 16'(FRAME_CYCLES - 1)) begin
			count <= 16'h0000;
		end else begin
			count <= count + 16'h0001;
		end
	end

	// Frame start pulse at the end of each full period
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			frame.sof <= 1'b0;
		end else begin
			frame.sof <= frame.run && count == 16'(FRAME_CYCLES - 1); // R1
		end
	end

endmodule : uhs_frame_timer

/* src/uhs_top.sv */
// Purpose: Functional state control and command/status registers of a USB host controller, APB slave.
// Assumes: Single 25 MHz clock mclk, asynchronous active-low nrst; resume_signal comes from a pin.
// Notes:   Registers are word indexed; byte address is index * 4. One wait state per access, more while a soft reset runs.
//
// What this block does
// [R1] First frame start 1 ms after entering running
// [R2] Hardware changes state only while suspended
// [R3] Suspended moves to resuming on downstream resume
// [R4] Any reset ends in bus reset state
// [R5] Hardware reset resets root hub, drives port reset
// [R6] Command/status writes are set-only
// [R7] Overrun increments count, sets overrun flag
// [R8] Count starts at zero, wraps after three
// [R9] Count increments even with flag set
// [R10] Software writes bit 0 to request reset
// [R11] Soft reset: suspended, registers cleared, bus stalled
// [R12] Request bit clears on completion, within 10 us
// [R13] Soft reset leaves root hub, ports alone
// [R14] Command/status at read and write code two
// [R15] State codes: reset, resume, running, suspended
// [R16] Frame start sets flag, emits token
// [R17] Software clears flags by writing ones
// [R18] Count and reserved bits ignore writes, read zero
`timescale 1ns/10ps
`include "uhs_consts.svh"
module uhs_top
	import uhs_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = `UHS_SOF_DELAY_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic resume_signal,
	input wire logic periodic_overrun,
	output logic sof_token,
	output logic [1:0] functional_state_field,
	output logic root_hub_reset,
	output logic port_reset_drive,
	output logic irq
);

	uhs_frame_if frame ();

	uhs_fstate_type fstate;
	uhs_fstate_type next_fstate;
	logic soft_reset_request;
	logic [7:0] srst_count;
	logic srst_done;
	logic [1:0] overrun_count;
	logic [31:0] int_flags;
	logic [31:0] int_mask;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic [5:0] word_idx;
	logic hit_control;
	logic hit_cmd;
	logic hit_flags;
	logic hit_mask;
	logic hit_any;
	logic resume_sync1;
	logic resume_sync2;
	logic resume_sync3;
	logic resume_level;
	logic resume_level_d;
	logic resume_rise;
	logic [31:0] flag_set;
	logic [31:0] flag_clear;
	logic [3:0] rh_count;
	logic hw_reset_origin;

	// Frame timer; counts only while running
	uhs_frame_timer #(
		.FRAME_CYCLES(FRAME_CYCLES)
	) u_frame_timer (
		.mclk(mclk),
		.nrst(nrst),
		.frame(frame)
	);

	assign frame.run = (fstate == running_state); // R1

	// Address decode on the word index
	assign word_idx = paddr[7:2];
	assign hit_control = (word_idx == `UHS_IDX_CONTROL);
	assign hit_cmd = (word_idx == `UHS_IDX_CMD_STATUS); // R14
	assign hit_flags = (word_idx == `UHS_IDX_INT_FLAGS);
	assign hit_mask = (word_idx == `UHS_IDX_INT_MASK);
	assign hit_any = hit_control || hit_cmd || hit_flags || hit_mask;

	// The completing edge of an APB access; effects happen here only
	assign access_done = psel && penable && pready;
	assign wr_done = access_done && pwrite;
	assign rd_done = access_done && !pwrite;

	// APB ready: one wait state, held off while a soft reset runs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready && !soft_reset_request; // R11
		end
	end

	// Read data and error chosen while the access waits
	// Reserved bits read zero; the overrun count has no write path
	always_comb begin
		next_prdata = `UHS_RESET_WORD;
		next_pslverr = 1'b0;
		if (pwrite) begin
			next_prdata = `UHS_RESET_WORD;
			next_pslverr = !hit_any;
		end else if (hit_control) begin
			next_prdata[`UHS_FSTATE_MSB:`UHS_FSTATE_LSB] = fstate;
		end else if (hit_cmd) begin
			next_prdata[`UHS_OVR_CNT_MSB:`UHS_OVR_CNT_LSB] = overrun_count;
			next_prdata[`UHS_SRST_BIT] = soft_reset_request; // R18
		end else if (hit_flags) begin
			next_prdata = int_flags;
		end else if (hit_mask) begin
			next_prdata = int_mask;
		end else begin
			next_pslverr = 1'b1;
		end
	end

	// Registered read data and error, loaded with ready
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata <= `UHS_RESET_WORD;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready && !soft_reset_request) begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end else if (access_done) begin
			prdata <= `UHS_RESET_WORD;
			pslverr <= 1'b0;
		end
	end

	// Resume pin synchroniser; first stage feeds only the second
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			resume_sync1 <= 1'b0;
			resume_sync2 <= 1'b0;
			resume_sync3 <= 1'b0;
		end else begin
			resume_sync1 <= resume_signal;
			resume_sync2 <= resume_sync1;
			resume_sync3 <= resume_sync2;
		end
	end

	// Accept a change once the second and third stages agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			resume_level <= 1'b0;
			resume_level_d <= 1'b0;
		end else begin
			if (resume_sync2 == resume_sync3) begin
				resume_level <= resume_sync3;
			end
			resume_level_d <= resume_level;
		end
	end

	assign resume_rise = resume_level && !resume_level_d;

	// Soft reset request: set by a write of one, cleared by the core when done
	// A write of zero leaves it alone; bus accesses stall while it is set
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			soft_reset_request <= 1'b0;
			srst_count <= 8'h00;
		end else if (soft_reset_request) begin
			if (srst_done) begin
				soft_reset_request <= 1'b0; // R12
				srst_count <= 8'h00;
			end else begin
				srst_count <= srst_count + 8'h01;
			end
		end else if (wr_done && hit_cmd && pwdata[`UHS_SRST_BIT]) begin
			soft_reset_request <= 1'b1; // R6 R10
		end
	end

	// Fixed duration, well inside the longest allowed reset time
	assign srst_done = (srst_count == `UHS_SRST_CYCLES - 8'h01); // R12

	// Functional state next value
	always_comb begin
		next_fstate = fstate;
		case (fstate)
			suspended_state: begin
				if (resume_rise) begin
					next_fstate = resuming_state; // R2 R3
				end
			end
			default: begin
				next_fstate = fstate; // R2
			end
		endcase
		// Software owns the field in every state
		if (wr_done && hit_control) begin
			next_fstate = uhs_fstate_type'(pwdata[`UHS_FSTATE_MSB:`UHS_FSTATE_LSB]); // R15
		end
		// Soft reset parks in suspended, then lands in bus reset
		if (soft_reset_request) begin
			next_fstate = srst_done ? bus_reset_state : suspended_state; // R4 R11
		end
	end

	// Functional state register; hardware reset enters bus reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fstate <= bus_reset_state; // R4 R15
		end else begin
			fstate <= next_fstate;
		end
	end

	// Overrun count: zero after reset, wraps, ignores writes and flag state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			overrun_count <= `UHS_RESET_OVR_CNT; // R8
		end else if (soft_reset_request) begin
			overrun_count <= `UHS_RESET_OVR_CNT; // R11
		end else if (periodic_overrun) begin
			overrun_count <= overrun_count + 2'h1; // R7 R8 R9 R18
		end
	end

	// Events and clears of the interrupt flags
	always_comb begin
		flag_set = `UHS_RESET_WORD;
		flag_set[`UHS_INT_OVERRUN] = periodic_overrun; // R7
		flag_set[`UHS_INT_FRAME_START] = frame.sof && frame.run; // R16
		flag_set[`UHS_INT_RESUME] = resume_rise;
		flag_clear = `UHS_RESET_WORD;
		// A read clears only what it reported; an event that lands on the
		// capture edge would otherwise be lost before software sees it
		if (rd_done && hit_flags) begin
			flag_clear = prdata & `UHS_INT_USED;
		end else if (wr_done && hit_flags) begin
			flag_clear = pwdata & `UHS_INT_USED; // R17
		end
	end

	// Sticky flags; a set in the clearing cycle survives
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			int_flags <= `UHS_RESET_WORD;
		end else if (soft_reset_request) begin
			int_flags <= `UHS_RESET_WORD; // R11
		end else begin
			int_flags <= ((int_flags & ~flag_clear) | flag_set) & `UHS_INT_USED;
		end
	end

	// Mask register, plain read and write, unused bits stay zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			int_mask <= `UHS_RESET_WORD;
		end else if (soft_reset_request) begin
			int_mask <= `UHS_RESET_WORD; // R11
		end else if (wr_done && hit_mask) begin
			int_mask <= pwdata & `UHS_INT_USED; // R18
		end
	end

	// Level interrupt, one cycle behind the flags
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_flags & int_mask);
		end
	end

	// Frame start token toward the link
	// Dropped when running ends on the same edge, since no frame follows
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sof_token <= 1'b0;
		end else begin
			sof_token <= frame.sof && frame.run; // R16
		end
	end

	// State seen by the rest of the controller
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			functional_state_field <= bus_reset_state;
		end else begin
			functional_state_field <= next_fstate;
		end
	end

	// Root hub reset: held through hardware reset and briefly after
	// Nothing else restarts this counter, so a soft reset leaves it idle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rh_count <= 4'h0;
			root_hub_reset <= 1'b1; // R5
		end else if (rh_count != `UHS_RH_RESET_CYCLES) begin
			rh_count <= rh_count + 4'h1;
			root_hub_reset <= 1'b1;
		end else begin
			root_hub_reset <= 1'b0; // R13
		end
	end

	// Port reset signaling follows only a hardware reset
	// A soft reset drops the origin, so ports are never reset by it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hw_reset_origin <= 1'b1; // R5
		end else if (soft_reset_request || next_fstate != bus_reset_state) begin
			hw_reset_origin <= 1'b0; // R13
		end
	end

	// Drive port reset while the hardware-reset bus reset state lasts
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			port_reset_drive <= 1'b0;
		end else begin
			port_reset_drive <= hw_reset_origin && !soft_reset_request &&
				next_fstate == bus_reset_state; // R5 R13
		end
	end

endmodule : uhs_top

/* verif/uhs_chk.sv */
// Purpose: Port assertions for uhs_top.
// Assumes: One mclk domain, nrst async active low.
// Notes:   Counter times frame starts against entry to running.
`timescale 1ns/10ps
`include "uhs_consts.svh"
module uhs_chk
	import uhs_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = 25000
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic resume_signal,
	input wire logic periodic_overrun,
	input wire logic sof_token,
	input wire logic [1:0] functional_state_field,
	input wire logic root_hub_reset,
	input wire logic port_reset_drive,
	input wire logic irq
);
	int unsigned run_cnt;
	logic seen_sof;
	wire logic done = psel && penable && pready;
	wire logic wr_ctl = done && pwrite && paddr[7:2] == `UHS_IDX_CONTROL;
	wire logic wr_cmd = done && pwrite && paddr[7:2] == `UHS_IDX_CMD_STATUS;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Cycles since running began or since the last frame start
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			run_cnt <= 0;
			seen_sof <= 1'b0;
		end else begin
			run_cnt <= (functional_state_field != running_state || sof_token) ? 0 : run_cnt + 1;
			seen_sof <= (functional_state_field == running_state) && (seen_sof || sof_token);
		end
	end

	property p_sof_time; sof_token |-> run_cnt == (seen_sof ? FRAME_CYCLES - 1 : FRAME_CYCLES + 1); endproperty
	a_sof_time: assert property (p_sof_time) else $error("frame start off time");
	property p_sof_run; sof_token |-> functional_state_field == running_state; endproperty
	a_sof_run: assert property (p_sof_run) else $error("frame start outside running");
	property p_hold; $changed(functional_state_field) |->
		$past(functional_state_field) == suspended_state || $past(wr_ctl) || $past(wr_cmd) || $past(wr_cmd, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("state changed by itself");
	property p_hw; $rose(nrst) |-> functional_state_field == bus_reset_state ##1 port_reset_drive; endproperty
	a_hw: assert property (p_hw) else $error("hardware reset end state wrong");
	property p_port; port_reset_drive |-> functional_state_field == bus_reset_state; endproperty
	a_port: assert property (p_port) else $error("port reset outside bus reset");
	property p_rh; $rose(nrst) |-> root_hub_reset [*8]; endproperty
	a_rh: assert property (p_rh) else $error("root hub reset too short");
	property p_rh_soft; !$rose(root_hub_reset); endproperty
	a_rh_soft: assert property (p_rh_soft) else $error("root hub reset while running");
	property p_srst; wr_cmd && pwdata[0] |=> ##[0:2] functional_state_field == suspended_state
		##[1:250] functional_state_field == bus_reset_state; endproperty
	a_srst: assert property (p_srst) else $error("soft reset path wrong");
	property p_cmd_rd; done && !pwrite && paddr[7:2] == `UHS_IDX_CMD_STATUS |-> (prdata & 32'hFFFC_FFFE) == 0; endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("reserved bits not zero");
	property p_err; pslverr |-> pready && !(paddr[7:2] inside {[6'h01:6'h04]}); endproperty
	a_err: assert property (p_err) else $error("error on mapped index");

	c_sof: cover property (sof_token);
	c_res: cover property ($past(functional_state_field) == suspended_state && functional_state_field == resuming_state);
	c_err: cover property (pslverr);
endmodule : uhs_chk

bind uhs_top uhs_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.*);

/* verif/uhs_host_model.sv */
// Purpose: Host driver model, APB master of uhs_top.
// Assumes: One transfer at a time, word addressed.
// Notes:   No cycle count assumed; the bench watchdog ends a hang.
`timescale 1ns/10ps
module uhs_host_model (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// Byte address is index times four; writes of ones clear flags
	task xfer(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Stale data never looks valid
	endtask : xfer
endmodule : uhs_host_model

/* verif/tb_top.sv */
// Purpose: Self-checking bench for uhs_top.
// Assumes: Short frame period to keep the run brief.
// Notes:   Exact frame timing also watched by the checker.
`timescale 1ns/10ps
`include "uhs_consts.svh"
module tb_top;
	import uhs_pkg::*;
	localparam int unsigned F = 50;
	logic mclk, nrst, resume_signal, periodic_overrun, psel, penable, pwrite, pready, pslverr;
	logic sof_token, root_hub_reset, port_reset_drive, irq, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] functional_state_field;
	int n_fail, checks_done, seed, n, k;

	uhs_top #(.FRAME_CYCLES(F)) dut (.*);
	uhs_host_model u_host (.*);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task end_sim;
		if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task wr(input logic [5:0] idx, input logic [31:0] d);
		u_host.xfer(1'b1, idx, d, q, e);
	endtask : wr

	task rd(input logic [5:0] idx);
		u_host.xfer(1'b0, idx, 32'h0000_0000, q, e);
	endtask : rd

	// One-cycle overrun pulses with a gap
	task ovr(input int cnt);
		repeat (cnt) begin
			@(posedge mclk);
			periodic_overrun <= 1'b1;
			@(posedge mclk);
			periodic_overrun <= 1'b0;
		end
	endtask : ovr

	task edges(input int cnt);
		repeat (cnt) @(posedge mclk);
		#1;
	endtask : edges

	function logic [31:0] cmd_exp(input int c);
		return {14'h0000, 2'(c), 16'h0000};
	endfunction : cmd_exp

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Longest expected run is a few hundred cycles
	initial begin
		#(40 * 20000);
		n_fail++;
		end_sim();
	end

	initial begin
		seed = 74066;
		n_fail = 0;
		checks_done = 0;
		nrst = 1'b0;
		resume_signal = 1'b0;
		periodic_overrun = 1'b0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		edges(1);
		chk(32'(functional_state_field), 32'h0);
		chk(32'(port_reset_drive), 32'h1);
		chk(32'(root_hub_reset), 32'h1);
		edges(10);
		chk(32'(root_hub_reset), 32'h0);
		rd(`UHS_IDX_CMD_STATUS);
		chk(q, cmd_exp(0));
		rd(6'h3F);
		chk(32'(e), 32'h1);
		wr(`UHS_IDX_CMD_STATUS, $random(seed) & 32'hFFFF_FFFE);
		rd(`UHS_IDX_CMD_STATUS);
		chk(q, cmd_exp(0));
		// Count wraps; flag stays set between bursts
		n = 0;
		for (int i = 0; i < 4; i++) begin
			k = (i == 0) ? 4 : {$random(seed)} % 6 + 1;
			n += k;
			ovr(k);
			rd(`UHS_IDX_CMD_STATUS);
			chk(q, cmd_exp(n));
		end
		rd(`UHS_IDX_INT_FLAGS);
		chk(q, 32'h1);
		rd(`UHS_IDX_INT_FLAGS);
		chk(q, 32'h0);
		wr(`UHS_IDX_INT_MASK, 32'h1);
		ovr(1);
		edges(2);
		chk(32'(irq), 32'h1);
		wr(`UHS_IDX_INT_FLAGS, 32'h1);
		edges(2);
		chk(32'(irq), 32'h0);
		wr(`UHS_IDX_INT_MASK, 32'h0);
		ovr(1);
		edges(2);
		chk(32'(irq), 32'h0);
		rd(`UHS_IDX_INT_FLAGS);
		chk(q, 32'h1);
		for (int s = 0; s < 4; s++) begin
			wr(`UHS_IDX_CONTROL, 32'(s) << 6);
			rd(`UHS_IDX_CONTROL);
			chk(32'(q[7:6]), 32'(s));
			chk(32'(functional_state_field), 32'(s));
		end
		resume_signal <= 1'b1;
		edges(8);
		chk(32'(functional_state_field), 32'(resuming_state));
		rd(`UHS_IDX_INT_FLAGS);
		chk(q & 32'h8, 32'h8);
		wr(`UHS_IDX_CONTROL, 32'(running_state) << 6);
		edges(10);
		chk(32'(functional_state_field), 32'(running_state));
		@(posedge mclk);
		resume_signal <= 1'b0;
		wr(`UHS_IDX_CONTROL, 32'(bus_reset_state) << 6);
		wr(`UHS_IDX_CONTROL, 32'(running_state) << 6);
		for (int p = 0; p < 2; p++) begin
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (sof_token !== 1'b1);
			chk(32'(k), (p == 0) ? 32'(F + 2) : 32'(F));
		end
		rd(`UHS_IDX_INT_FLAGS);
		chk(q & 32'h4, 32'h4);
		wr(`UHS_IDX_INT_MASK, 32'h5);
		ovr(1);
		wr(`UHS_IDX_CMD_STATUS, 32'h1);
		rd(`UHS_IDX_CMD_STATUS);
		chk(q, cmd_exp(0));
		chk(32'(functional_state_field), 32'(bus_reset_state));
		rd(`UHS_IDX_INT_MASK);
		chk(q, 32'h0);
		chk(32'({root_hub_reset, port_reset_drive}), 32'h0);
		end_sim();
	end
endmodule : tb_top
